//--- hdl/programmable_input_conditioner.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - each line debounced by programmable time
// - active level programmable high or low
// - open pins read high, idle high
// - any input reflectable onto chosen output
// - head, handset, programming line are one
// - special lines stay ordinary unless dedicated
// - aux input two powers up emergency
// - aux input three acts as ignition
// - option line seven controls power by logic
module programmable_input_conditioner
  import input_cond_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] aux_input_one_to_three,
  input wire logic [3:0] aux_bidir_lines_four_to_seven,
  input wire logic [6:0] internal_option_lines_one_to_seven,
  input wire logic head_shared_line,
  output logic [NUM_LINES-1:0] line_active,
  output logic [NUM_OUTS-1:0] reflect_out,
  output logic [NUM_OUTS-1:0] reflect_out_used,
  output logic emergency_power_up,
  output logic ignition_power_on,
  output logic logic_power_on
);
  typedef struct packed {
    logic [NUM_LINES-1:0] active;
    logic [NUM_OUTS-1:0] refl;
    logic [NUM_OUTS-1:0] used;
    logic emerg;
    logic ign;
    logic lpow;
  } top_t;

  top_t state_reg;
  top_t state_next;
  logic [NUM_LINES-1:0] raw;
  logic [NUM_LINES-1:0] deb_level;
  logic [NUM_LINES-1:0] pol;
  logic [2:0] ded;
  logic [NUM_LINES*DEB_W-1:0] deb_cfg;
  logic [NUM_LINES*(OUT_W+1)-1:0] mir_cfg;

  // one shared head line
  // handset and programming connectors wire to the same pin
  assign raw = {head_shared_line, internal_option_lines_one_to_seven,
                aux_bidir_lines_four_to_seven, aux_input_one_to_three};

  apb_regs u_regs (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .state_in(state_reg.active),
    .raw_in(raw),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pol_out(pol),
    .ded_out(ded),
    .deb_out(deb_cfg),
    .mir_out(mir_cfg)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      line_debouncer u_deb (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin_in(raw[g]),
        .deb_cycles(deb_cfg[g*DEB_W +: DEB_W]),
        .level_out(deb_level[g])
      );
    end
  endgenerate

  // resolve polarity, reflect and power functions
  always_comb begin
    state_next = state_reg;
    // pol bit 0 means active low, so an open pin reads inactive
    state_next.active = deb_level ~^ pol;
    state_next.refl = '0;
    state_next.used = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (mir_cfg[i*(OUT_W+1) + MIR_EN_BIT]) begin
        state_next.used[mir_cfg[i*(OUT_W+1) +: OUT_W]] = 1'b1;
        if (state_next.active[i]) begin
          state_next.refl[mir_cfg[i*(OUT_W+1) +: OUT_W]] = 1'b1;
        end
      end
    end
    state_next.emerg = ded[DED_EMERG_BIT] && state_next.active[LINE_AUX_TWO];
    state_next.ign = ded[DED_IGN_BIT] && state_next.active[LINE_AUX_THREE];
    state_next.lpow = ded[DED_LOGIC_BIT] && state_next.active[LINE_OPT_SEVEN];
  end

  // registered outputs; all inactive in reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // a line in dedicated use still reports its state, as in general use
  assign line_active = state_reg.active;
  assign reflect_out = state_reg.refl;
  assign reflect_out_used = state_reg.used;
  assign emergency_power_up = state_reg.emerg;
  assign ignition_power_on = state_reg.ign;
  assign logic_power_on = state_reg.lpow;

  a_polarity_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    line_active == $past(deb_level ~^ pol)
    ) else $error("active state not polarity of debounced level");
  a_emerg_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    emergency_power_up |-> $past(ded[DED_EMERG_BIT])
    ) else $error("emergency without dedicated enable");
  a_ign_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ignition_power_on == $past(ded[DED_IGN_BIT] &&
      (deb_level[LINE_AUX_THREE] ~^ pol[LINE_AUX_THREE]))
    ) else $error("ignition output wrong");
  a_logic_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    logic_power_on == $past(ded[DED_LOGIC_BIT] &&
      (deb_level[LINE_OPT_SEVEN] ~^ pol[LINE_OPT_SEVEN]))
    ) else $error("logic power output wrong");
  a_reflect_src: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reflect_out & ~reflect_out_used) == '0
    ) else $error("reflected output set without a source");
  a_open_pin_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ($past(deb_level[0]) && !$past(pol[0])) |-> !line_active[0]
    ) else $error("open active-low pin read active");
  a_shared_line: assert property (@(posedge clk_sys) disable iff (!rst_b)
    raw[NUM_LINES-1] == head_shared_line
    ) else $error("shared head line not mapped");
  a_aux_one_plain: assert property (@(posedge clk_sys) disable iff (!rst_b)
    line_active[LINE_AUX_ONE] == $past(deb_level[0] ~^ pol[0])
    ) else $error("aux one not ordinary input");
endmodule : programmable_input_conditioner
`default_nettype wire

//--- hdl/input_cond_pkg.sv
package input_cond_pkg;
  // line count: aux 1..3, aux bidir 4..7, options 1..7, shared head line
  localparam int unsigned NUM_LINES = 15;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned DEB_W = 24;
  localparam int unsigned NUM_OUTS = 8;
  localparam int unsigned OUT_W = 3;

  // line indices
  localparam logic [IDX_W-1:0] LINE_AUX_ONE = 4'h0;
  localparam logic [IDX_W-1:0] LINE_AUX_TWO = 4'h1;
  localparam logic [IDX_W-1:0] LINE_AUX_THREE = 4'h2;
  // option line seven is bit 6 of the option group, after aux 1..7
  localparam logic [IDX_W-1:0] LINE_OPT_SEVEN = 4'hd;

  // register byte offsets
  localparam logic [11:0] ADDR_POLARITY = 12'h000;
  localparam logic [11:0] ADDR_DEDICATED = 12'h004;
  localparam logic [11:0] ADDR_STATE = 12'h008;
  localparam logic [11:0] ADDR_RAW = 12'h00c;
  localparam logic [11:0] ADDR_DEB_BASE = 12'h040;
  localparam logic [11:0] ADDR_MIR_BASE = 12'h080;
  localparam logic [11:0] ADDR_SPAN = 12'h03c;

  // reflect control field layout
  localparam int unsigned MIR_EN_BIT = 3;

  // dedicated function enable bits
  localparam int unsigned DED_EMERG_BIT = 0;
  localparam int unsigned DED_IGN_BIT = 1;
  localparam int unsigned DED_LOGIC_BIT = 2;

  // reset values; pins idle high through pullups
  localparam logic [NUM_LINES-1:0] POL_RESET = 15'h0000;
  localparam logic [NUM_LINES-1:0] PIN_IDLE = 15'h7fff;
  localparam logic [DEB_W-1:0] DEB_RESET = 24'h000001;

  // recommended debounce for switches, 50 ms, at 40 MHz
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DEB_SWITCH_MS = 50;
  localparam logic [DEB_W-1:0] DEB_SWITCH_CYC =
    DEB_W'(CLK_HZ / 1000 * DEB_SWITCH_MS);
endpackage : input_cond_pkg

//--- hdl/line_debouncer.sv
`timescale 1ns/100ps
`default_nettype none
module line_debouncer
  import input_cond_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin_in,
  input wire logic [DEB_W-1:0] deb_cycles,
  output logic level_out
);
  typedef struct packed {
    logic last;
    logic stable;
    logic [DEB_W-1:0] cnt;
  } deb_t;

  deb_t state_reg;
  deb_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.last = pin_in;
    if (pin_in != state_reg.last) begin
      state_next.cnt = '0;
    end else if (pin_in != state_reg.stable) begin
      if (state_reg.cnt + DEB_W'(1) >= deb_cycles) begin
        state_next.stable = pin_in;
        state_next.cnt = '0;
      end else begin
        state_next.cnt = state_reg.cnt + DEB_W'(1);
      end
    end else begin
      state_next.cnt = '0;
    end
  end

  // idle high matches pullup on an open pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{last: 1'b1, stable: 1'b1, cnt: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.stable;

  a_stable_no_glitch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(state_reg.stable) |-> $past(pin_in) == state_reg.stable
    ) else $error("stable level changed without matching input");
endmodule : line_debouncer
`default_nettype wire

//--- hdl/apb_regs.sv
`timescale 1ns/100ps
`default_nettype none
module apb_regs
  import input_cond_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NUM_LINES-1:0] state_in,
  input wire logic [NUM_LINES-1:0] raw_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_LINES-1:0] pol_out,
  output logic [2:0] ded_out,
  output logic [NUM_LINES*DEB_W-1:0] deb_out,
  output logic [NUM_LINES*(OUT_W+1)-1:0] mir_out
);
  typedef struct packed {
    logic [NUM_LINES-1:0] pol;
    logic [2:0] ded;
    logic [NUM_LINES*DEB_W-1:0] deb;
    logic [NUM_LINES*(OUT_W+1)-1:0] mir;
    logic [31:0] rdata;
    logic err;
  } regs_t;

  regs_t state_reg;
  regs_t state_next;
  logic [IDX_W-1:0] idx;
  logic access;

  assign access = psel && penable;
  assign idx = paddr[5:2];
  assign pready = 1'b1;

  // decode in access phase; one-cycle, zero-wait answer
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    state_next.err = 1'b0;
    if (!access) begin
      state_next.err = 1'b0;
    end else if (paddr == ADDR_POLARITY) begin
      if (pwrite) state_next.pol = pwdata[NUM_LINES-1:0];
      state_next.rdata = 32'(state_reg.pol);
    end else if (paddr == ADDR_DEDICATED) begin
      if (pwrite) state_next.ded = pwdata[2:0];
      state_next.rdata = 32'(state_reg.ded);
    end else if (paddr == ADDR_STATE) begin
      state_next.rdata = 32'(state_in);
    end else if (paddr == ADDR_RAW) begin
      state_next.rdata = 32'(raw_in);
    end else if (paddr >= ADDR_DEB_BASE && paddr < ADDR_DEB_BASE + ADDR_SPAN
                 + 12'h004 && paddr[1:0] == 2'b00 && idx < 4'hf) begin
      if (pwrite) state_next.deb[idx*DEB_W +: DEB_W] = pwdata[DEB_W-1:0];
      state_next.rdata = 32'(state_reg.deb[idx*DEB_W +: DEB_W]);
    end else if (paddr >= ADDR_MIR_BASE && paddr < ADDR_MIR_BASE + ADDR_SPAN
                 + 12'h004 && paddr[1:0] == 2'b00 && idx < 4'hf) begin
      if (pwrite) state_next.mir[idx*(OUT_W+1) +: OUT_W+1] = pwdata[OUT_W:0];
      state_next.rdata = 32'(state_reg.mir[idx*(OUT_W+1) +: OUT_W+1]);
    end else begin
      state_next.err = 1'b1;
    end
  end

  // register copy; debounce starts at minimum
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{pol: POL_RESET, ded: 3'h0, deb: {NUM_LINES{DEB_RESET}},
                     mir: '0, rdata: '0, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // read data combinational from state to meet zero-wait timing
  assign prdata = state_next.rdata;
  assign pslverr = state_next.err;
  assign pol_out = state_reg.pol;
  assign ded_out = state_reg.ded;
  assign deb_out = state_reg.deb;
  assign mir_out = state_reg.mir;
endmodule : apb_regs
`default_nettype wire

//--- testbench/line_source.sv
`timescale 1ns/100ps
`default_nettype none
module line_source (
  input wire logic clk_sys,
  input wire logic [14:0] level_req,
  input wire logic [14:0] jitter_req,
  output logic [14:0] pins
);
  logic [14:0] flip_reg = 15'h0000;
  // a bouncing switch flips each cycle, a logic source never does
  always @(posedge clk_sys) begin
    flip_reg <= flip_reg ^ jitter_req;
  end
  // a settled source holds its requested level indefinitely
  assign pins = level_req ^ (flip_reg & jitter_req);
endmodule : line_source
`default_nettype wire

//--- testbench/programmable_input_conditioner_tb.sv
`timescale 1ns/100ps
`default_nettype none
module programmable_input_conditioner_tb;
  import input_cond_pkg::*;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rd_err;
  logic [14:0] want, jit, pins, line_active;
  logic [7:0] reflect_out, reflect_out_used;
  logic emergency_power_up, ignition_power_on, logic_power_on;
  int mismatches = 0;
  int total_checks = 0;
  line_source u_src (.clk_sys(clk_sys), .level_req(want),
    .jitter_req(jit), .pins(pins));
  programmable_input_conditioner u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_input_one_to_three(pins[2:0]),
    .aux_bidir_lines_four_to_seven(pins[6:3]),
    .internal_option_lines_one_to_seven(pins[13:7]),
    .head_shared_line(pins[14]), .line_active(line_active),
    .reflect_out(reflect_out), .reflect_out_used(reflect_out_used),
    .emergency_power_up(emergency_power_up),
    .ignition_power_on(ignition_power_on), .logic_power_on(logic_power_on));
  // 40 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer; waits on pready rather than assuming zero wait
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 50) begin
      mismatches++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bounded wait for a recognised level change
  task wait_act(input int i, input logic v);
    int n;
    n = 0;
    while (line_active[i] !== v && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    chk("line_active", 32'(v), 32'(line_active[i]));
  endtask : wait_act
  // idle-high pins are inactive with reset polarity
  task t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk("polarity", 32'h0, rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("debounce", 32'h1, rd);
    chk("idle", 32'h0, 32'(line_active));
    apb(1'b1, 12'h000, 32'h1);
    wait_act(0, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    wait_act(0, 1'b0);
  endtask : t_reset
  // debounced change, restart on bounce, reflection
  task t_debounce;
    apb(1'b1, 12'h040, 32'h8);
    apb(1'b1, 12'h080, 32'hd);
    want[0] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("early", 32'h0, 32'(line_active[0]));
    chk("reflect raw", 32'h0, 32'(reflect_out[5]));
    wait_act(0, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk("reflect", 32'h1, 32'(reflect_out[5]));
    chk("used", 32'h1, 32'(reflect_out_used[5]));
    want[0] <= 1'b1;
    jit[0] <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("bounce", 32'h1, 32'(line_active[0]));
    jit[0] <= 1'b0;
    wait_act(0, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk("reflect off", 32'h0, 32'(reflect_out[5]));
  endtask : t_debounce
  task t_dedicated;
    logic [2:0] got;
    want[1] <= 1'b0; want[2] <= 1'b0; want[13] <= 1'b0; want[14] <= 1'b0;
    wait_act(14, 1'b1);
    wait_act(13, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk("state", 32'h6006, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("raw", 32'h1ff9, rd);
    repeat (3) @(posedge clk_sys);
    got = {logic_power_on, ignition_power_on, emergency_power_up};
    chk("dedicated off", 32'h0, 32'(got));
    apb(1'b1, 12'h004, 32'h7);
    repeat (3) @(posedge clk_sys);
    got = {logic_power_on, ignition_power_on, emergency_power_up};
    chk("dedicated on", 32'h7, 32'(got));
    want <= PIN_IDLE;
    wait_act(14, 1'b0);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", 32'h1, 32'(rd_err));
  endtask : t_dedicated
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // watchdog well past the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; want = PIN_IDLE; jit = 15'h0000;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_debounce();
    t_dedicated();
    print_verdict();
  end
endmodule : programmable_input_conditioner_tb
`default_nettype wire
